// ### rtl/cpap_dev.sv
`timescale 1ns/1ps
module cpap_dev (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  cpap_if.dev bus,
  input wire logic [11:0] periph_addr_in,
  input wire logic [31:0] periph_hw_in,
  output logic [31:0] periph_value_out
);
  typedef struct packed {
    logic [31:0][7:0] wregs;
    logic [7:0] direct_ext;
    logic [7:0] first_ext;
    logic [7:0] second_ext;
    logic [7:0] third_ext;
    logic [7:0] jump_ext;
    logic [23:0] temp;
    logic io_unlock_mode;
    logic instr_unlock;
    logic [2:0] unlock_cnt;
    logic [23:0] mem_addr;
  } cpap_dev_st_t;
  cpap_dev_st_t st_reg;
  cpap_dev_st_t st_next;
  logic periph_we;
  logic periph_re;
  logic [7:0] periph_rdata;
  logic [23:0] periph_temp;
  logic periph_temp_we;

  // ==========================================================
  // Helpers
  function automatic logic [15:0] ptr_of(input cpap_dev_st_t s, input logic [1:0] sel);
    logic [4:0] lo;
    lo = (sel == 2'h0) ? cpap_pkg::PTR_FIRST_LO :
         (sel == 2'h1) ? cpap_pkg::PTR_SECOND_LO : cpap_pkg::PTR_THIRD_LO;
    return {s.wregs[lo + 5'h1], s.wregs[lo]};
  endfunction : ptr_of

  function automatic logic [7:0] ext_of(input cpap_dev_st_t s, input logic [1:0] sel);
    return (sel == 2'h0) ? s.first_ext : (sel == 2'h1) ? s.second_ext : s.third_ext;
  endfunction : ext_of

  // ==========================================================
  // Peripheral register sharing the temporary bytes
  wire periph_sel = bus.io_addr[11:2] == periph_addr_in[11:2];
  assign periph_we = bus.io_we && periph_sel;
  assign periph_re = bus.io_re && periph_sel;
  wire [1:0] periph_byte = bus.io_addr[1:0] - periph_addr_in[1:0];
  cpap_wide_reg u_wide (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .we_in(periph_we),
    .re_in(periph_re),
    .byte_in(periph_byte),
    .wdata_in(bus.io_wdata),
    .temp_in(st_reg.temp),
    .hw_value_in(periph_hw_in),
    .value_out(periph_value_out),
    .rdata_out(periph_rdata),
    .temp_out(periph_temp),
    .temp_we_out(periph_temp_we)
  );

  // ==========================================================
  // Operand read ports, combinational for single-cycle access
  // single-cycle reads
  always_comb begin
    bus.op_a = st_reg.wregs[bus.rd_a];
    bus.op_b = st_reg.wregs[bus.rd_b];
    bus.op_w = {st_reg.wregs[{bus.rd_a[4:1], 1'b1}], st_reg.wregs[{bus.rd_a[4:1], 1'b0}]};
  end

  // I/O read mux
  always_comb begin
    bus.io_hit = 1'b1;
    unique case (bus.io_addr)
      cpap_pkg::OFS_CHANGE_PROTECT_KEY: bus.io_rdata = {6'h00, st_reg.instr_unlock,
                                                       st_reg.io_unlock_mode};
      cpap_pkg::OFS_DIRECT_EXT: bus.io_rdata = st_reg.direct_ext;
      cpap_pkg::OFS_FIRST_EXT: bus.io_rdata = st_reg.first_ext;
      cpap_pkg::OFS_SECOND_EXT: bus.io_rdata = st_reg.second_ext;
      cpap_pkg::OFS_THIRD_EXT: bus.io_rdata = st_reg.third_ext;
      cpap_pkg::OFS_JUMP_EXT: bus.io_rdata = st_reg.jump_ext;
      cpap_pkg::OFS_TEMP0: bus.io_rdata = st_reg.temp[7:0];
      cpap_pkg::OFS_TEMP1: bus.io_rdata = st_reg.temp[15:8];
      cpap_pkg::OFS_TEMP2: bus.io_rdata = st_reg.temp[23:16];
      default: begin
        bus.io_rdata = periph_rdata;
        bus.io_hit = periph_sel;
      end
    endcase
  end

  assign bus.mem_addr = st_reg.mem_addr;
  assign bus.io_unlock = st_reg.io_unlock_mode;
  assign bus.instr_unlock = st_reg.instr_unlock;
  assign bus.irq_block = st_reg.io_unlock_mode | st_reg.instr_unlock;

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [15:0] ptr;
    logic [15:0] upd;
    logic [4:0] lo;
    st_next = st_reg;
    ptr = ptr_of(st_reg, bus.ptr_sel);
    upd = ptr;
    lo = (bus.ptr_sel == 2'h0) ? cpap_pkg::PTR_FIRST_LO :
         (bus.ptr_sel == 2'h1) ? cpap_pkg::PTR_SECOND_LO : cpap_pkg::PTR_THIRD_LO;
    // Result writeback; no data memory path into the file
    if (bus.wr_en) begin
      unique case (bus.acc)
        cpap_pkg::CPAP_ACC_B1_R8, cpap_pkg::CPAP_ACC_B2_R8: begin
          st_next.wregs[bus.wr_sel] = bus.wr_data[7:0];
        end
        cpap_pkg::CPAP_ACC_B2_R16, cpap_pkg::CPAP_ACC_W1_R16: begin
          st_next.wregs[{bus.wr_sel[4:1], 1'b0}] = bus.wr_data[7:0];
          st_next.wregs[{bus.wr_sel[4:1], 1'b1}] = bus.wr_data[15:8];
        end
        default: ;
      endcase
    end
    // Memory address formation
    if (bus.mem_go) begin
      unique case (bus.asrc)
        cpap_pkg::CPAP_AS_PTR_DATA: begin
          unique case (bus.pmode)
            cpap_pkg::CPAP_PTR_DISP: ptr = ptr + {10'h000, bus.disp};
            cpap_pkg::CPAP_PTR_INC: upd = ptr + 16'h0001;
            cpap_pkg::CPAP_PTR_DEC: begin
              upd = ptr - 16'h0001;
              ptr = upd;
            end
            default: ;
          endcase
          st_next.mem_addr = {ext_of(st_reg, bus.ptr_sel), ptr};
          st_next.wregs[lo] = upd[7:0];
          st_next.wregs[lo + 5'h1] = upd[15:8];
        end
        cpap_pkg::CPAP_AS_DIRECT: st_next.mem_addr = {st_reg.direct_ext, bus.direct_op};
        // plain load ignores extension; third pointer
        cpap_pkg::CPAP_AS_PLOAD: st_next.mem_addr = {8'h00, ptr_of(st_reg, 2'h2)};
        cpap_pkg::CPAP_AS_XPLOAD, cpap_pkg::CPAP_AS_PSTORE: begin
          st_next.mem_addr = {st_reg.third_ext, ptr_of(st_reg, 2'h2)};
        end
        cpap_pkg::CPAP_AS_JUMP: st_next.mem_addr = {st_reg.jump_ext, ptr_of(st_reg, 2'h2)};
        default: ;
      endcase
    end
    // Unlock window countdown; caller acts within four cycles
    if (st_reg.unlock_cnt != 3'h0) begin
      st_next.unlock_cnt = st_reg.unlock_cnt - 3'h1;
      if (st_reg.unlock_cnt == 3'h1) begin
        st_next.io_unlock_mode = 1'b0;
        st_next.instr_unlock = 1'b0;
      end
    end
    if (bus.io_we || bus.dmem_we || bus.pstore_exec || bus.pload_exec || bus.sleep_exec) begin
      st_next.io_unlock_mode = 1'b0;
    end
    if (bus.dmem_we || bus.sleep_exec) begin
      st_next.instr_unlock = 1'b0;
    end
    // I/O register writes
    if (bus.io_we) begin
      unique case (bus.io_addr)
        cpap_pkg::OFS_CHANGE_PROTECT_KEY: begin
          // key decode; any other key closes both unlocks and clears the count
          st_next.io_unlock_mode = bus.io_wdata == cpap_pkg::KEY_IO_UNLOCK;
          st_next.instr_unlock = bus.io_wdata == cpap_pkg::KEY_INSTR_UNLOCK;
          st_next.unlock_cnt = (st_next.io_unlock_mode | st_next.instr_unlock) ?
                               cpap_pkg::UNLOCK_CYCLES : 3'h0;
        end
        cpap_pkg::OFS_DIRECT_EXT: st_next.direct_ext = bus.io_wdata & cpap_pkg::DATA_EXT_MASK;
        cpap_pkg::OFS_FIRST_EXT: st_next.first_ext = bus.io_wdata & cpap_pkg::DATA_EXT_MASK;
        cpap_pkg::OFS_SECOND_EXT: st_next.second_ext = bus.io_wdata & cpap_pkg::DATA_EXT_MASK;
        cpap_pkg::OFS_THIRD_EXT: st_next.third_ext = bus.io_wdata & cpap_pkg::DATA_EXT_MASK;
        cpap_pkg::OFS_JUMP_EXT: st_next.jump_ext = bus.io_wdata & cpap_pkg::JUMP_EXT_MASK;
        cpap_pkg::OFS_TEMP0: st_next.temp[7:0] = bus.io_wdata;
        cpap_pkg::OFS_TEMP1: st_next.temp[15:8] = bus.io_wdata;
        cpap_pkg::OFS_TEMP2: st_next.temp[23:16] = bus.io_wdata;
        default: ;
      endcase
    end
    if (periph_temp_we) begin
      st_next.temp = periph_temp;
    end
  end

  // State register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end
endmodule : cpap_dev

// ### rtl/cpap_pkg.sv
package cpap_pkg;
  // ==========================================================
  // Register file geometry
  localparam int unsigned NUM_WREGS = 32;
  localparam int unsigned WREG_AW = 5;
  localparam logic [4:0] PTR_FIRST_LO = 5'h1A;
  localparam logic [4:0] PTR_SECOND_LO = 5'h1C;
  localparam logic [4:0] PTR_THIRD_LO = 5'h1E;
  // ==========================================================
  // I/O offsets of the support registers
  localparam logic [11:0] OFS_CHANGE_PROTECT_KEY = 12'h004;
  localparam logic [11:0] OFS_DIRECT_EXT = 12'h008;
  localparam logic [11:0] OFS_FIRST_EXT = 12'h009;
  localparam logic [11:0] OFS_SECOND_EXT = 12'h00A;
  localparam logic [11:0] OFS_THIRD_EXT = 12'h00B;
  localparam logic [11:0] OFS_JUMP_EXT = 12'h00C;
  // Temporary bytes for multi-byte peripheral access
  localparam logic [11:0] OFS_TEMP0 = 12'h010;
  localparam logic [11:0] OFS_TEMP1 = 12'h011;
  localparam logic [11:0] OFS_TEMP2 = 12'h012;
  // ==========================================================
  // Keys, status bits, reset values, timing
  localparam logic [7:0] KEY_INSTR_UNLOCK = 8'h9D;
  localparam logic [7:0] KEY_IO_UNLOCK = 8'hD8;
  localparam int unsigned BIT_IO_UNLOCK = 0;
  localparam int unsigned BIT_INSTR_UNLOCK = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Implemented extension bits (memory span dependent)
  localparam logic [7:0] DATA_EXT_MASK = 8'hFF;
  localparam logic [7:0] JUMP_EXT_MASK = 8'hFF;
  // ==========================================================
  // Register file access patterns
  typedef enum logic [3:0] {
    CPAP_ACC_B1_R8 = 4'h1,
    CPAP_ACC_B2_R8 = 4'h2,
    CPAP_ACC_B2_R16 = 4'h4,
    CPAP_ACC_W1_R16 = 4'h8
  } cpap_acc_t;
  // Pointer update modes
  typedef enum logic [2:0] {
    CPAP_PTR_DISP = 3'h1,
    CPAP_PTR_INC = 3'h2,
    CPAP_PTR_DEC = 3'h4
  } cpap_ptrmode_t;
  // Address source for the memory side
  typedef enum logic [5:0] {
    CPAP_AS_PTR_DATA = 6'h01,
    CPAP_AS_DIRECT = 6'h02,
    CPAP_AS_PLOAD = 6'h04,
    CPAP_AS_XPLOAD = 6'h08,
    CPAP_AS_PSTORE = 6'h10,
    CPAP_AS_JUMP = 6'h20
  } cpap_asrc_t;
endpackage : cpap_pkg

// ### rtl/cpap_if.sv
`timescale 1ns/1ps
// ==========================================================
// Pipeline to support-logic link
interface cpap_if;
  logic [4:0] rd_a;
  logic [4:0] rd_b;
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic [15:0] op_w;
  logic wr_en;
  cpap_pkg::cpap_acc_t acc;
  logic [4:0] wr_sel;
  logic [15:0] wr_data;
  logic mem_go;
  cpap_pkg::cpap_asrc_t asrc;
  logic [1:0] ptr_sel;
  cpap_pkg::cpap_ptrmode_t pmode;
  logic [5:0] disp;
  logic [15:0] direct_op;
  logic [23:0] mem_addr;
  logic io_we;
  logic io_re;
  logic [11:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_hit;
  logic dmem_we;
  logic sleep_exec;
  logic pstore_exec;
  logic pload_exec;
  logic io_unlock;
  logic instr_unlock;
  logic irq_block;
  modport dev (
    input rd_a, rd_b, wr_en, acc, wr_sel, wr_data, mem_go, asrc, ptr_sel, pmode,
    input disp, direct_op, io_we, io_re, io_addr, io_wdata, dmem_we,
    input sleep_exec, pstore_exec, pload_exec,
    output op_a, op_b, op_w, mem_addr, io_rdata, io_hit, io_unlock, instr_unlock,
    output irq_block
  );
  modport cpu (
    output rd_a, rd_b, wr_en, acc, wr_sel, wr_data, mem_go, asrc, ptr_sel, pmode,
    output disp, direct_op, io_we, io_re, io_addr, io_wdata, dmem_we,
    output sleep_exec, pstore_exec, pload_exec,
    input op_a, op_b, op_w, mem_addr, io_rdata, io_hit, io_unlock, instr_unlock,
    input irq_block
  );
endinterface : cpap_if

// ### rtl/cpap_wide_reg.sv
`timescale 1ns/1ps
// ==========================================================
// Peripheral-side 32-bit register with atomic byte access
module cpap_wide_reg (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic re_in,
  input wire logic [1:0] byte_in,
  input wire logic [7:0] wdata_in,
  input wire logic [23:0] temp_in,
  input wire logic [31:0] hw_value_in,
  output logic [31:0] value_out,
  output logic [7:0] rdata_out,
  output logic [23:0] temp_out,
  output logic temp_we_out
);
  typedef struct packed {
    logic [31:0] value;
  } cpap_wide_st_t;
  cpap_wide_st_t st_reg;
  cpap_wide_st_t st_next;

  // Writes land in temp until the top byte commits all four at once
  always_comb begin
    st_next = st_reg;
    temp_out = temp_in;
    temp_we_out = 1'b0;
    rdata_out = 8'h00;
    if (we_in) begin
      if (byte_in == 2'h3) begin
        st_next.value = {wdata_in, temp_in};
      end else begin
        temp_out[8*byte_in +: 8] = wdata_in;
        temp_we_out = 1'b1;
      end
    end
    if (re_in) begin
      if (byte_in == 2'h0) begin
        // Snapshot upper bytes so later reads stay coherent
        rdata_out = hw_value_in[7:0];
        temp_out = hw_value_in[31:8];
        temp_we_out = 1'b1;
      end else begin
        rdata_out = temp_in[8*(byte_in-2'h1) +: 8];
      end
    end
  end

  // State register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end
  assign value_out = st_reg.value;
endmodule : cpap_wide_reg

// ### rtl/cpap_cpu.sv
`timescale 1ns/1ps
// ==========================================================
// Pipeline end: turns user requests into link cycles
module cpap_cpu (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  cpap_if.cpu bus,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [11:0] io_addr_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic [4:0] rd_a_in,
  input wire logic [4:0] rd_b_in,
  input wire logic reg_wr_in,
  input wire cpap_pkg::cpap_acc_t acc_in,
  input wire logic [4:0] wr_sel_in,
  input wire logic [15:0] wr_data_in,
  input wire logic mem_go_in,
  input wire cpap_pkg::cpap_asrc_t asrc_in,
  input wire logic [1:0] ptr_sel_in,
  input wire cpap_pkg::cpap_ptrmode_t pmode_in,
  input wire logic [5:0] disp_in,
  input wire logic [15:0] direct_in,
  input wire logic dmem_we_in,
  input wire logic sleep_in,
  input wire logic pstore_in,
  input wire logic pload_in,
  output logic [7:0] io_rdata_out,
  output logic [7:0] op_a_out,
  output logic [7:0] op_b_out,
  output logic [23:0] mem_addr_out,
  output logic irq_hold_out
);
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] op_a;
    logic [7:0] op_b;
  } cpap_cpu_st_t;
  cpap_cpu_st_t st_reg;
  cpap_cpu_st_t st_next;

  // Requests pass straight through; the device registers them
  always_comb begin
    bus.io_we = io_wr_in;
    bus.io_re = io_rd_in;
    bus.io_addr = io_addr_in;
    bus.io_wdata = io_wdata_in;
    bus.rd_a = rd_a_in;
    bus.rd_b = rd_b_in;
    bus.wr_en = reg_wr_in;
    bus.acc = acc_in;
    bus.wr_sel = wr_sel_in;
    bus.wr_data = wr_data_in;
    bus.mem_go = mem_go_in;
    bus.asrc = asrc_in;
    bus.ptr_sel = ptr_sel_in;
    bus.pmode = pmode_in;
    bus.disp = disp_in;
    bus.direct_op = direct_in;
    bus.dmem_we = dmem_we_in;
    bus.sleep_exec = sleep_in;
    bus.pstore_exec = pstore_in;
    bus.pload_exec = pload_in;
  end

  // Capture read data so user outputs come from flops
  always_comb begin
    st_next = st_reg;
    if (io_rd_in) begin
      st_next.rdata = bus.io_rdata;
    end
    st_next.op_a = bus.op_a;
    st_next.op_b = bus.op_b;
  end

  // State register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end
  assign io_rdata_out = st_reg.rdata;
  assign op_a_out = st_reg.op_a;
  assign op_b_out = st_reg.op_b;
  assign mem_addr_out = bus.mem_addr;
  assign irq_hold_out = bus.irq_block;
endmodule : cpap_cpu

// ### dv/cpap_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Link checker: sees only the link signals between both ends
module cpap_monitor (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [11:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_hit,
  input wire logic dmem_we,
  input wire logic sleep_exec,
  input wire logic pstore_exec,
  input wire logic pload_exec,
  input wire logic io_unlock,
  input wire logic instr_unlock,
  input wire logic irq_block,
  input wire logic mem_go,
  input wire cpap_pkg::cpap_asrc_t asrc,
  input wire logic [15:0] direct_op,
  input wire logic [23:0] mem_addr
);
  // Key decode and events that end the register unlock
  logic key_wr, key_io, key_ins, io_ev;
  assign key_wr = io_we && (io_addr == cpap_pkg::OFS_CHANGE_PROTECT_KEY);
  assign key_io = key_wr && (io_wdata == cpap_pkg::KEY_IO_UNLOCK);
  assign key_ins = key_wr && (io_wdata == cpap_pkg::KEY_INSTR_UNLOCK);
  assign io_ev = io_we || dmem_we || pstore_exec || pload_exec || sleep_exec;
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Unlock behaviour
  AST_IO_KEY: assert property (key_io |=> io_unlock)
    else $error("io unlock not set by its key");
  AST_INS_KEY: assert property (key_ins |=> instr_unlock && !io_unlock)
    else $error("instr unlock not set by its key");
  AST_BAD_KEY: assert property (key_wr && !key_io && !key_ins |=> !io_unlock && !instr_unlock)
    else $error("wrong key left an unlock open");
  AST_IO_HOLD: assert property (key_io ##1 (!io_ev)[*4] |-> io_unlock)
    else $error("io unlock ended before four cycles");
  AST_IO_EXPIRE: assert property (key_io ##1 (!io_ev)[*4] |=> !io_unlock)
    else $error("io unlock outlived four cycles");
  AST_IO_END: assert property (io_unlock && io_ev && !key_io |=> !io_unlock)
    else $error("io unlock survived a cancelling event");
  AST_INS_END: assert property (instr_unlock && (dmem_we || sleep_exec) && !key_ins
    |=> !instr_unlock)
    else $error("instr unlock survived a cancelling event");
  AST_IRQ_HOLD: assert property (irq_block == (io_unlock || instr_unlock))
    else $error("interrupt hold does not follow the unlocks");
  // ==========================================================
  // Read data and address forming
  AST_KEY_READ: assert property (io_re && io_addr == cpap_pkg::OFS_CHANGE_PROTECT_KEY
    |-> io_rdata == {6'h00, instr_unlock, io_unlock})
    else $error("key register status read wrong");
  AST_UNMAPPED: assert property (io_re && !io_hit |-> io_rdata == 8'h00)
    else $error("unmapped read returned data");
  AST_DIRECT: assert property (mem_go && asrc == cpap_pkg::CPAP_AS_DIRECT
    |=> mem_addr[15:0] == $past(direct_op))
    else $error("direct address low word wrong");
endmodule : cpap_monitor

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %s exp %0h got %0h", nm, (e), (g)); end end
// ==========================================================
// Bench: both ends joined, user side of the pipeline end driven
module tb_top;
  localparam logic [11:0] KEY_OFS = cpap_pkg::OFS_CHANGE_PROTECT_KEY;
  localparam logic [31:0] SNAP = 32'hCAFEF00D;
  logic mclk = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, reg_wr = 1'b0, mem_go = 1'b0;
  logic [11:0] io_adr = 12'h000;
  logic [7:0] io_wd = 8'h00;
  logic [4:0] rd_a = 5'h00, rd_b = 5'h00, wr_sel = 5'h00;
  logic [15:0] wr_data = 16'h0000, direct = 16'h0000;
  cpap_pkg::cpap_acc_t acc = cpap_pkg::CPAP_ACC_B1_R8;
  cpap_pkg::cpap_asrc_t asrc = cpap_pkg::CPAP_AS_PTR_DATA;
  cpap_pkg::cpap_ptrmode_t pmode = cpap_pkg::CPAP_PTR_DISP;
  logic [1:0] ptr_sel = 2'h0;
  logic [5:0] disp = 6'h00;
  logic [3:0] ev = 4'h0;
  logic [31:0] hw = 32'h0, pval;
  logic [7:0] io_rdata, op_a, op_b;
  logic [23:0] mem_addr;
  logic irq_hold;
  int n_fail = 0;
  int compares = 0;
  cpap_if cpap_if_i ();
  cpap_dev cpap_dev_i (.mclk_in(mclk), .rst_in(rst), .ce_in(1'b1), .bus(cpap_if_i.dev),
    .periph_addr_in(12'h020), .periph_hw_in(hw), .periph_value_out(pval));
  cpap_cpu cpap_cpu_i (.mclk_in(mclk), .rst_in(rst), .ce_in(1'b1), .bus(cpap_if_i.cpu),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(io_adr), .io_wdata_in(io_wd),
    .rd_a_in(rd_a), .rd_b_in(rd_b), .reg_wr_in(reg_wr), .acc_in(acc), .wr_sel_in(wr_sel),
    .wr_data_in(wr_data), .mem_go_in(mem_go), .asrc_in(asrc), .ptr_sel_in(ptr_sel),
    .pmode_in(pmode), .disp_in(disp), .direct_in(direct), .dmem_we_in(ev[0]),
    .pstore_in(ev[1]), .pload_in(ev[2]), .sleep_in(ev[3]), .io_rdata_out(io_rdata),
    .op_a_out(op_a), .op_b_out(op_b), .mem_addr_out(mem_addr), .irq_hold_out(irq_hold));
  cpap_monitor cpap_monitor_i (.mclk_in(mclk), .rst_in(rst), .io_we(cpap_if_i.io_we),
    .io_re(cpap_if_i.io_re), .io_addr(cpap_if_i.io_addr), .io_wdata(cpap_if_i.io_wdata),
    .io_rdata(cpap_if_i.io_rdata), .io_hit(cpap_if_i.io_hit), .dmem_we(cpap_if_i.dmem_we),
    .sleep_exec(cpap_if_i.sleep_exec), .pstore_exec(cpap_if_i.pstore_exec),
    .pload_exec(cpap_if_i.pload_exec), .io_unlock(cpap_if_i.io_unlock),
    .instr_unlock(cpap_if_i.instr_unlock), .irq_block(cpap_if_i.irq_block),
    .mem_go(cpap_if_i.mem_go), .asrc(cpap_if_i.asrc), .direct_op(cpap_if_i.direct_op),
    .mem_addr(cpap_if_i.mem_addr));
  // 20 MHz clock
  initial begin
    forever #25 mclk = ~mclk;
  end
  // ==========================================================
  // Link cycles: start at a falling edge; a strobe stays up until the next task
  // Sets every strobe once, so back-to-back calls never glitch one low
  task automatic strobes(input logic w, input logic r, input logic g, input logic m);
    io_wr = w;
    io_rd = r;
    reg_wr = g;
    mem_go = m;
  endtask : strobes
  task automatic io_w(input logic [11:0] a, input logic [7:0] d);
    strobes(1'b1, 1'b0, 1'b0, 1'b0);
    io_adr = a;
    io_wd = d;
    @(negedge mclk);
  endtask : io_w
  task automatic io_r(input logic [11:0] a, output logic [7:0] d);
    strobes(1'b0, 1'b1, 1'b0, 1'b0);
    io_adr = a;
    @(negedge mclk);
    d = io_rdata;
  endtask : io_r
  task automatic rf_wr(input cpap_pkg::cpap_acc_t a, input logic [4:0] s, input logic [15:0] d);
    strobes(1'b0, 1'b0, 1'b1, 1'b0);
    acc = a;
    wr_sel = s;
    wr_data = d;
    @(negedge mclk);
  endtask : rf_wr
  // Operand outputs are registered, so one edge before looking
  task automatic rf_rd(input logic [4:0] a, input logic [4:0] b);
    strobes(1'b0, 1'b0, 1'b0, 1'b0);
    rd_a = a;
    rd_b = b;
    @(negedge mclk);
  endtask : rf_rd
  task automatic mem_chk(input cpap_pkg::cpap_asrc_t s, input logic [1:0] p,
      input logic [23:0] e, input cpap_pkg::cpap_ptrmode_t m = cpap_pkg::CPAP_PTR_DISP,
      input logic [5:0] d = 6'h00);
    strobes(1'b0, 1'b0, 1'b0, 1'b1);
    asrc = s;
    ptr_sel = p;
    pmode = m;
    disp = d;
    @(negedge mclk);
    `CHK("mem_addr", e, mem_addr)
  endtask : mem_chk
  // Single-cycle pulse on one of dmem, pstore, pload, sleep
  task automatic pulse(input int k);
    strobes(1'b0, 1'b0, 1'b0, 1'b0);
    ev = 4'(1 << k);
    @(negedge mclk);
    ev = 4'h0;
  endtask : pulse
  // ==========================================================
  // Scenarios
  task automatic t_rf();
    for (int i = 0; i < 32; i++) rf_wr(cpap_pkg::CPAP_ACC_B1_R8, 5'(i), {11'h005, 5'(i)});
    for (int i = 0; i < 32; i++) begin
      rf_rd(5'(i), 5'(31 - i));
      `CHK("op_a", {3'h5, 5'(i)}, op_a)
      `CHK("op_b", {3'h5, 5'(31 - i)}, op_b)
    end
    rf_wr(cpap_pkg::CPAP_ACC_B2_R8, 5'h03, 16'h0077);
    rf_wr(cpap_pkg::CPAP_ACC_B2_R16, 5'h04, 16'hBEEF);
    rf_wr(cpap_pkg::CPAP_ACC_W1_R16, 5'h06, 16'h1234);
    rf_rd(5'h03, 5'h05);
    `CHK("op_a", 8'h77, op_a)
    `CHK("op_b", 8'hBE, op_b)
    rf_rd(5'h06, 5'h04);
    `CHK("op_w", 16'h1234, cpap_if_i.op_w)
    `CHK("op_b", 8'hEF, op_b)
  endtask : t_rf
  // Extension bytes at 0x08..0x0C get 11,22,33,44,55
  task automatic t_ptr();
    logic [7:0] v;
    for (int k = 0; k < 5; k++) begin
      io_r(cpap_pkg::OFS_DIRECT_EXT + 12'(k), v);
      `CHK("ext reset", 8'h00, v)
      io_w(cpap_pkg::OFS_DIRECT_EXT + 12'(k), {4'(k + 1), 4'(k + 1)});
      io_r(cpap_pkg::OFS_DIRECT_EXT + 12'(k), v);
      `CHK("ext rw", {4'(k + 1), 4'(k + 1)}, v)
    end
    rf_wr(cpap_pkg::CPAP_ACC_B2_R16, cpap_pkg::PTR_FIRST_LO, 16'h10FF);
    rf_wr(cpap_pkg::CPAP_ACC_B2_R16, cpap_pkg::PTR_SECOND_LO, 16'h2000);
    rf_wr(cpap_pkg::CPAP_ACC_B2_R16, cpap_pkg::PTR_THIRD_LO, 16'h3000);
    mem_chk(cpap_pkg::CPAP_AS_PTR_DATA, 2'h0, 24'h2210FF, cpap_pkg::CPAP_PTR_INC);
    rf_rd(5'h1A, 5'h1B);
    `CHK("x lo", 8'h00, op_a)
    `CHK("x hi", 8'h11, op_b)
    mem_chk(cpap_pkg::CPAP_AS_PTR_DATA, 2'h1, 24'h331FFF, cpap_pkg::CPAP_PTR_DEC);
    rf_rd(5'h1C, 5'h1D);
    `CHK("y lo", 8'hFF, op_a)
    `CHK("y hi", 8'h1F, op_b)
    mem_chk(cpap_pkg::CPAP_AS_PTR_DATA, 2'h2, 24'h44303F, cpap_pkg::CPAP_PTR_DISP, 6'h3F);
    rf_rd(5'h1E, 5'h1F);
    `CHK("z kept", 8'h30, op_b)
    direct = 16'hABCD;
    mem_chk(cpap_pkg::CPAP_AS_DIRECT, 2'h2, 24'h11ABCD);
    mem_chk(cpap_pkg::CPAP_AS_PLOAD, 2'h2, 24'h003000);
    mem_chk(cpap_pkg::CPAP_AS_XPLOAD, 2'h2, 24'h443000);
    mem_chk(cpap_pkg::CPAP_AS_PSTORE, 2'h2, 24'h443000);
    mem_chk(cpap_pkg::CPAP_AS_JUMP, 2'h2, 24'h553000);
    io_r(12'h01A, v);
    `CHK("unmapped", 8'h00, v)
  endtask : t_ptr
  // Wide register at 0x020: write commits on byte 3, read snaps on byte 0
  task automatic t_wide();
    logic [7:0] v;
    for (int k = 0; k < 3; k++) io_w(12'h020 + 12'(k), 8'(k + 1));
    `CHK("value held", 32'h0, pval)
    for (int k = 0; k < 3; k++) begin
      io_r(cpap_pkg::OFS_TEMP0 + 12'(k), v);
      `CHK("temp", 8'(k + 1), v)
    end
    io_w(12'h023, 8'h04);
    `CHK("value", 32'h04030201, pval)
    hw = SNAP;
    io_r(12'h020, v);
    hw = 32'h12345678;
    `CHK("byte0", 8'h0D, v)
    for (int k = 1; k < 4; k++) begin
      io_r(12'h020 + 12'(k), v);
      `CHK("snap", 8'(SNAP >> (8 * k)), v)
    end
    io_w(cpap_pkg::OFS_TEMP2, 8'h5A);
    io_r(cpap_pkg::OFS_TEMP2, v);
    `CHK("temp rw", 8'h5A, v)
  endtask : t_wide
  task automatic t_ccp();
    logic [7:0] v;
    io_r(KEY_OFS, v);
    `CHK("key reset", 8'h00, v)
    io_w(KEY_OFS, cpap_pkg::KEY_IO_UNLOCK);
    io_r(KEY_OFS, v);
    `CHK("io status", 8'h01, v)
    `CHK("irq hold", 1'b1, irq_hold)
    strobes(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (2) @(negedge mclk);
    `CHK("io window", 1'b1, cpap_if_i.io_unlock)
    @(negedge mclk);
    `CHK("io expired", 1'b0, cpap_if_i.io_unlock)
    `CHK("irq free", 1'b0, irq_hold)
    // Every cancelling event, the plain I/O write last
    for (int k = 0; k < 5; k++) begin
      io_w(KEY_OFS, cpap_pkg::KEY_IO_UNLOCK);
      if (k == 4) io_w(cpap_pkg::OFS_TEMP0, 8'h00);
      else pulse(k);
      `CHK("io cancel", 1'b0, cpap_if_i.io_unlock)
    end
    for (int k = 0; k < 4; k += 3) begin
      io_w(KEY_OFS, cpap_pkg::KEY_INSTR_UNLOCK);
      io_r(KEY_OFS, v);
      `CHK("instr status", 8'h02, v)
      pulse(k);
      `CHK("instr cancel", 1'b0, cpap_if_i.instr_unlock)
    end
    io_w(KEY_OFS, cpap_pkg::KEY_IO_UNLOCK);
    io_w(KEY_OFS, 8'h55);
    io_r(KEY_OFS, v);
    `CHK("bad key", 8'h00, v)
  endtask : t_ccp
  // ==========================================================
  // Verdict and run control
  task automatic stop_test();
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // Reset for ten cycles, then the scenarios in turn
  initial begin
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    t_rf();
    t_ptr();
    t_wide();
    t_ccp();
    stop_test();
  end
  // Run needs well under 1000 cycles; twenty times that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end
endmodule : tb_top
